// file: design/adc_ctrl_pkg.sv
/*
 * Constants shared by the converter control block: register offsets,
 * field positions, reset values, timing counts and sequencer states.
 * Assumes an 8-bit special function register space.
 */
package adc_ctrl_pkg;
    // Register offsets in the special function register space.
    localparam logic [7:0] CONV_CONTROL_ADDR = 8'h00_C0;
    localparam logic [7:0] RESULT_LOW_ADDR   = 8'h00_C1;
    localparam logic [7:0] RESULT_HIGH_ADDR  = 8'h00_C2;
    localparam logic [7:0] PIN_SWITCH_ADDR   = 8'h00_C6;

    // Field positions of the conversion control register.
    localparam int CC_ENABLE_BIT   = 7;
    localparam int CC_EXT_BIT      = 5;
    localparam int CC_FLAG_BIT     = 4;
    localparam int CC_START_BIT    = 3;
    localparam int CC_CHAN_LSB     = 0;
    localparam int CHAN_WIDTH      = 3;

    // Field positions of the result low and clock select register.
    localparam int RL_CLKSEL_LSB   = 6;
    localparam int RESULT_WIDTH    = 10;
    localparam int RESULT_LOW_BITS = 2;

    // Reset values of the writable fields.
    localparam logic [7:0] CONTROL_RESET    = 8'h00_00;
    localparam logic [1:0] CLKSEL_RESET     = 2'h0;
    localparam logic [7:0] PIN_SWITCH_RESET = 8'h00_00;

    // Clock select codes; the last code is reserved.
    localparam logic [1:0] CLKSEL_DIV4  = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
    localparam logic [1:0] CLKSEL_DIV16 = 2'h2;

    // Conversion length in machine cycles and divider ratios.
    localparam int CONV_CYCLES = 50;
    localparam int DIV_SLOW    = 16;
    localparam int DIV_MID     = 8;
    localparam int DIV_FAST    = 4;

    // Sequencer states, Gray coded along idle, converting, finishing.
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_CONV   = 2'b01,
        SEQ_FINISH = 2'b11
    } seq_state_t;
endpackage

// file: design/conv_link_if.sv
/*
 * Carrier between the register side and the conversion sequencer.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface conv_link_if;
    logic       start;   // One-cycle request to begin converting.
    logic       abort;   // Level that stops a running conversion.
    logic [1:0] clkSel;  // Converter clock divider code.
    logic       busy;    // Sequencer is converting.
    logic       done;    // One-cycle pulse on the last cycle.

    modport ctrl (output start, output abort, output clkSel,
                  input busy, input done);
    modport seq  (input start, input abort, input clkSel,
                  output busy, output done);
endinterface

// file: design/conv_sequencer.sv
/*
 * Conversion sequencer: times one conversion in machine cycles and
 * generates the divided converter clock.
 * Assumes start arrives only when idle; the owner filters requests.
 */
`timescale 1ns/1ps
module conv_sequencer
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  rstSyncN,
    conv_link_if.seq   link,
    output logic       adcClk
);
    // Width wide enough for the conversion length.
    localparam int CW = $clog2(CONV_LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(CONV_LEN - 1);

    seq_state_t    state;     // Sequencer state.
    logic [CW-1:0] cnt;       // Machine cycles elapsed in the conversion.
    logic [3:0]    divCnt;    // Half-period counter of the converter clock.
    logic [3:0]    halfLen;   // Half period for the selected divider.

    // The finishing cycle is the last of the conversion window.
    assign link.busy = (state != SEQ_IDLE);
    assign link.done = (state == SEQ_FINISH);

    // Conversion timing; abort wins over everything else.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state <= SEQ_IDLE;
            cnt   <= '0;
        end else if (link.abort) begin
            state <= SEQ_IDLE;
            cnt   <= '0;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    if (link.start) begin
                        state <= SEQ_CONV;
                        cnt   <= CW'(1);
                    end
                end
                SEQ_CONV: begin
                    cnt <= cnt + CW'(1);
                    if (cnt == LAST) begin
                        state <= SEQ_FINISH;
                    end
                end
                SEQ_FINISH: begin
                    state <= SEQ_IDLE;
                    cnt   <= '0;
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Half period per code; the reserved code falls back to the slowest
    // ratio so a careless setting never overclocks the converter.
    always_comb begin
        case (link.clkSel)
            CLKSEL_DIV4:  halfLen = 4'(DIV_FAST / 2);
            CLKSEL_DIV8:  halfLen = 4'(DIV_MID / 2);
            CLKSEL_DIV16: halfLen = 4'(DIV_SLOW / 2);
            default:      halfLen = 4'(DIV_SLOW / 2);
        endcase
    end

    // Free running divider toggling the converter clock.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            divCnt <= '0;
            adcClk <= 1'b0;
        end else if (divCnt >= halfLen - 4'd1) begin
            divCnt <= '0;
            adcClk <= ~adcClk;
        end else begin
            divCnt <= divCnt + 4'd1;
        end
    end
endmodule

// file: design/sar_adc_conversion_control.sv
/*
 * Register side of the successive approximation converter control:
 * the special function registers, start qualification, result capture
 * and the analog pin switch.
 * Assumes the core clock is the machine-cycle clock, the register port
 * and all inputs are synchronous to it, and the analog core presents a
 * settled result when the conversion window ends.
 */
`timescale 1ns/1ps
module sar_adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic [7:0]                   sfrAddr,
    input  wire logic                         sfrWrEn,
    input  wire logic                         sfrRdEn,
    input  wire logic [7:0]                   sfrWrData,
    output logic      [7:0]                   sfrRdData,
    input  wire logic                         external_start_pin,
    input  wire logic                         powerDown,
    input  wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0] anaResult,
    output logic                              anaEnable,
    output logic      [adc_ctrl_pkg::CHAN_WIDTH-1:0]   anaChannel,
    output logic                              anaConvert,
    output logic                              adcClk,
    output logic      [7:0]                   anaPinMode,
    output logic                              adcIrq
);
    import adc_ctrl_pkg::*;

    // Reset release chain.
    logic rstMeta;   // First stage, read only by the second.
    logic rstSyncN;  // Released reset used by all other logic.

    // Conversion control register fields.
    logic                  converter_enable;       // Converter on.
    logic                  external_start_enable;  // Start pin allowed.
    logic                  conversion_complete_flag; // Sticky done.
    logic                  conversion_start;       // Start and busy.
    logic [CHAN_WIDTH-1:0] channel_select;         // Input channel.

    // Other register contents.
    logic [1:0]              converter_clock_divider; // Divider code.
    logic [RESULT_WIDTH-1:0] result;                  // Last result.
    logic [7:0]              analog_pin_switch;       // Pin modes.

    // Start pin history for edge qualification.
    logic pinNow;   // Pin level at the end of this machine cycle.
    logic pinPrev;  // Pin level one machine cycle earlier.
    logic extEdge;  // Qualified rising edge.

    // Decoded write strobes.
    logic wrControl;  // Write to the control register.
    logic wrLow;      // Write to the result low register.
    logic wrPins;     // Write to the pin switch register.

    // Start qualification terms.
    logic swStart;    // Software asks for a start.
    logic startOk;    // A start may be accepted now.
    logic next_start; // Start accepted this cycle.

    // Link to the sequencer.
    conv_link_if link ();

    // Two-stage release of the asynchronous reset.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Address decode of the register port writes.
    assign wrControl = sfrWrEn && (sfrAddr == CONV_CONTROL_ADDR);
    assign wrLow     = sfrWrEn && (sfrAddr == RESULT_LOW_ADDR);
    assign wrPins    = sfrWrEn && (sfrAddr == PIN_SWITCH_ADDR);

    // The pin is synchronous, so one stage of history suffices; the
    // low and the high halves must each last a machine cycle.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinNow  <= 1'b0;
            pinPrev <= 1'b0;
        end else begin
            pinNow  <= external_start_pin;
            pinPrev <= pinNow;
        end
    end

    assign extEdge = pinNow && !pinPrev;

    // Software start is a write of one to the start bit.
    assign swStart = wrControl && sfrWrData[CC_START_BIT];

    // Gate every start on enable, idle, clear flag and no power-down.
    // A control write supplies the enable it carries, so a start written
    // with enable is accepted and one written with enable clear is not.
    always_comb begin
        startOk = wrControl ? sfrWrData[CC_ENABLE_BIT] : converter_enable;
        startOk = startOk && !conversion_start && !link.busy;
        startOk = startOk && !conversion_complete_flag;
        startOk = startOk && !powerDown;
        next_start = startOk && (swStart || (external_start_enable && extEdge));
    end

    // Enable, external start enable and channel are plain fields.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            converter_enable      <= CONTROL_RESET[CC_ENABLE_BIT];
            external_start_enable <= CONTROL_RESET[CC_EXT_BIT];
            channel_select        <= CONTROL_RESET[CC_CHAN_LSB +: CHAN_WIDTH];
        end else if (wrControl) begin
            converter_enable      <= sfrWrData[CC_ENABLE_BIT];
            external_start_enable <= sfrWrData[CC_EXT_BIT];
            channel_select        <= sfrWrData[CC_CHAN_LSB +: CHAN_WIDTH];
        end
    end

    // The start bit doubles as the busy indication seen by software.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            conversion_start <= CONTROL_RESET[CC_START_BIT];
        end else if (powerDown || (wrControl && !sfrWrData[CC_ENABLE_BIT])) begin
            conversion_start <= 1'b0;
        end else if (link.done) begin
            conversion_start <= 1'b0;
        end else if (next_start) begin
            conversion_start <= 1'b1;
        end
    end

    // Completion flag: hardware only sets it. A completion in the same
    // cycle as a software clear wins, so no result goes unannounced.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            conversion_complete_flag <= CONTROL_RESET[CC_FLAG_BIT];
        end else if (link.done && !powerDown) begin
            conversion_complete_flag <= 1'b1;
        end else if (wrControl && !sfrWrData[CC_FLAG_BIT]) begin
            conversion_complete_flag <= 1'b0;
        end
    end

    // Result capture happens on the same edge as flag and start change.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            result <= '0;
        end else if (link.done && !powerDown) begin
            result <= anaResult;
        end
    end

    // Clock select lives beside the result bits; writes there touch
    // only the divider.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            converter_clock_divider <= CLKSEL_RESET;
        end else if (wrLow) begin
            converter_clock_divider <= sfrWrData[RL_CLKSEL_LSB +: 2];
        end
    end

    // Pin switch register.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            analog_pin_switch <= PIN_SWITCH_RESET;
        end else if (wrPins) begin
            analog_pin_switch <= sfrWrData;
        end
    end

    // Registered read port; unmapped addresses read as zero and a
    // write to the result high register is simply not decoded.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            sfrRdData <= '0;
        end else if (sfrRdEn) begin
            case (sfrAddr)
                CONV_CONTROL_ADDR: begin
                    sfrRdData <= {converter_enable, 1'b0,
                                  external_start_enable,
                                  conversion_complete_flag,
                                  conversion_start, 1'b0,
                                  channel_select[1:0]} |
                                 {5'h00, channel_select[2], 2'h0};
                end
                RESULT_LOW_ADDR: begin
                    sfrRdData <= {converter_clock_divider, 4'h0,
                                  result[RESULT_LOW_BITS-1:0]};
                end
                RESULT_HIGH_ADDR: begin
                    sfrRdData <= result[RESULT_WIDTH-1:RESULT_LOW_BITS];
                end
                PIN_SWITCH_ADDR: begin
                    sfrRdData <= analog_pin_switch;
                end
                default: begin
                    sfrRdData <= '0;
                end
            endcase
        end
    end

    // Drives toward the analog core, all from flip-flops.
    always_ff @(posedge core_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            anaEnable  <= 1'b0;
            anaChannel <= '0;
            anaConvert <= 1'b0;
            anaPinMode <= '0;
            adcIrq     <= 1'b0;
        end else begin
            anaEnable  <= converter_enable && !powerDown;
            anaChannel <= channel_select;
            anaConvert <= next_start || (link.busy && !link.done && !link.abort);
            anaPinMode <= analog_pin_switch;
            // Built from the flag's next value so request and flag switch together.
            // request follows flag
            adcIrq     <= (conversion_complete_flag && !(wrControl && !sfrWrData[CC_FLAG_BIT])) ||
                          (link.done && !powerDown);
        end
    end

    // Handshake into the sequencer.
    assign link.start  = next_start;
    assign link.abort  = powerDown || (wrControl && !sfrWrData[CC_ENABLE_BIT]);
    assign link.clkSel = converter_clock_divider;

    // Conversion timer and converter clock divider.
    conv_sequencer #(
        .CONV_LEN (CONV_LEN)
    ) u_seq (
        .clk      (core_clk),
        .rstSyncN (rstSyncN),
        .link     (link),
        .adcClk   (adcClk)
    );
endmodule

// file: verification/sar_adc_conversion_control_assertions.sv
/*
 * Port checker for the converter control block: start qualification,
 * conversion length, completion flag and abort behaviour.
 * Assumes it is bound to the top module and shares its clock and reset.
 */
`timescale 1ns/1ps
module sar_adc_conversion_control_assertions #(
    parameter int CONV_LEN = adc_ctrl_pkg::CONV_CYCLES
) (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic       external_start_pin,
    input wire logic       powerDown,
    input wire logic       anaEnable,
    input wire logic       anaConvert,
    input wire logic       adcIrq
);
    import adc_ctrl_pkg::*;
    localparam int LAST = CONV_LEN - 1;
    logic       ctlEn;    // Shadow of the enable field.
    logic       extEn;    // Shadow of the external start enable.
    logic       pinPrev;  // Start pin as seen at the previous edge.
    logic [7:0] runCnt;   // Cycles the converting level has already stood.
    logic       wrCtl;    // Write to the control register.
    logic       idle;     // Nothing blocks a new start.
    logic       abortReq; // Power-down or a write that clears the enable.
    assign wrCtl = sfrWrEn && (sfrAddr == CONV_CONTROL_ADDR);
    assign idle = !anaConvert && !adcIrq && !powerDown;
    assign abortReq = powerDown || (wrCtl && !sfrWrData[CC_ENABLE_BIT]);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Shadows follow control writes so that a start can be predicted.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctlEn <= 1'b0;
            extEn <= 1'b0;
        end else if (wrCtl) begin
            ctlEn <= sfrWrData[CC_ENABLE_BIT];
            extEn <= sfrWrData[CC_EXT_BIT];
        end
    end
    // Counting from the rise of converting pins the end to an exact cycle.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pinPrev <= 1'b0;
            runCnt <= 8'h00;
        end else begin
            pinPrev <= external_start_pin;
            runCnt <= anaConvert ? runCnt + 8'h01 : 8'h00;
        end
    end
    sequence s_swStart;
        wrCtl && sfrWrData[CC_ENABLE_BIT] && sfrWrData[CC_START_BIT] && idle;
    endsequence
    sequence s_pinEdge;
        ctlEn && idle && !sfrWrEn && external_start_pin && !pinPrev;
    endsequence
    sequence s_finish;
        (anaConvert && !adcIrq) ##1 (adcIrq && !anaConvert);
    endsequence
    AST_SW_START: assert property (s_swStart |=> $rose(anaConvert))
        else $error("software start did not begin a conversion");
    AST_EXT_START: assert property (s_pinEdge and extEn |-> ##[1:2] $rose(anaConvert))
        else $error("qualified pin edge did not begin a conversion");
    AST_EXT_OFF: assert property (s_pinEdge and !extEn |-> ##1 !anaConvert ##1 !anaConvert)
        else $error("pin edge started a conversion with external start off");
    AST_CONV_RUN: assert property (anaConvert && runCnt < 8'(LAST) && !abortReq |=> anaConvert && !adcIrq)
        else $error("conversion ended early or was disturbed");
    AST_CONV_END: assert property (anaConvert && runCnt == 8'(LAST) && !abortReq |-> s_finish)
        else $error("conversion did not end with the flag at the set length");
    AST_FLAG_HOLD: assert property (adcIrq && !(wrCtl && !sfrWrData[CC_FLAG_BIT]) |=> adcIrq)
        else $error("completion flag cleared without a software write");
    AST_FLAG_CLEAR: assert property (adcIrq && !anaConvert && wrCtl && !sfrWrData[CC_FLAG_BIT] |=> !adcIrq)
        else $error("software write did not clear the completion flag");
    AST_ABORT: assert property (anaConvert && runCnt < 8'(LAST) && abortReq |=> !anaConvert && !adcIrq)
        else $error("abort did not stop the conversion cleanly");
    AST_BLOCK_FLAG: assert property (adcIrq && !anaConvert && wrCtl && sfrWrData[CC_START_BIT] |=> !anaConvert)
        else $error("start accepted while the completion flag was set");
    AST_PD_ENABLE: assert property (powerDown |=> !anaEnable)
        else $error("converter enabled during power-down");
endmodule
bind sar_adc_conversion_control sar_adc_conversion_control_assertions #(.CONV_LEN(CONV_LEN)) u_chk (
    .core_clk, .rstn, .sfrAddr, .sfrWrEn, .sfrWrData, .external_start_pin,
    .powerDown, .anaEnable, .anaConvert, .adcIrq);

// file: verification/analog_core_model.sv
/*
 * Behavioural comparator and ladder core facing the control block.
 * Assumes the result is sampled on the completion edge only.
 */
`timescale 1ns/1ps
module analog_core_model (
    input  wire logic                                   clk,
    input  wire logic                                   anaEnable,
    input  wire logic [adc_ctrl_pkg::CHAN_WIDTH-1:0]    anaChannel,
    input  wire logic                                   anaConvert,
    input  wire logic [adc_ctrl_pkg::RESULT_WIDTH-1:0]  level,
    output logic      [adc_ctrl_pkg::RESULT_WIDTH-1:0]  anaResult
);
    import adc_ctrl_pkg::*;
    // Outside a conversion the output churns, so a stale sample shows up.
    logic [RESULT_WIDTH-1:0] churn = '0;
    always_ff @(posedge clk) begin
        churn <= churn + 10'h001;
    end
    assign anaResult = (anaEnable && anaConvert) ? (level ^ {7'h00, anaChannel}) : churn;
endmodule

// file: verification/sar_adc_conversion_control_tb.sv
/*
 * Self-checking bench for the converter control block.
 * Assumes the analog core model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module sar_adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    localparam int LEN = CONV_CYCLES;
    logic       core_clk;
    logic       rstn;
    logic [7:0] sfrAddr;
    logic       sfrWrEn;
    logic       sfrRdEn;
    logic [7:0] sfrWrData;
    logic [7:0] sfrRdData;
    logic       external_start_pin;
    logic       powerDown;
    logic [9:0] anaResult;
    logic       anaEnable;
    logic [2:0] anaChannel;
    logic       anaConvert;
    logic       adcClk;
    logic [7:0] anaPinMode;
    logic       adcIrq;
    logic [9:0] level;
    logic [9:0] r;
    logic [7:0] v;
    logic [2:0] ch;
    logic [1:0] cs;
    logic       last;
    int         n;
    int         numErrors;
    int         samplesChecked;
    sar_adc_conversion_control #(.CONV_LEN(LEN)) u_dut (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .external_start_pin(external_start_pin), .powerDown(powerDown), .anaResult(anaResult),
        .anaEnable(anaEnable), .anaChannel(anaChannel), .anaConvert(anaConvert), .adcClk(adcClk),
        .anaPinMode(anaPinMode), .adcIrq(adcIrq));
    analog_core_model u_core (.clk(core_clk), .anaEnable(anaEnable), .anaChannel(anaChannel),
        .anaConvert(anaConvert), .level(level), .anaResult(anaResult));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Expected result: the core returns its level mixed with the channel.
    function automatic logic [9:0] expResult(input logic [9:0] lv, input logic [2:0] c);
        return lv ^ {7'h00, c};
    endfunction
    // Half period of the converter clock; the reserved code runs slowest.
    function automatic int halfOf(input logic [1:0] c);
        return (c == CLKSEL_DIV4) ? DIV_FAST / 2 : (c == CLKSEL_DIV8) ? DIV_MID / 2 : DIV_SLOW / 2;
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(posedge core_clk);
        #1;
        sfrWrEn = 1'b0;
    endtask
    // Read data is registered and holds, so it is taken one edge later.
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        #1;
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(posedge core_clk);
        #1;
        sfrRdEn = 1'b0;
        @(posedge core_clk);
        #1;
        check({2'b00, sfrRdData}, {2'b00, e});
    endtask
    // The pin stays low a full cycle, then high, so both halves are seen.
    task automatic pulse();
        @(posedge core_clk);
        #1;
        external_start_pin = 1'b0;
        @(posedge core_clk);
        #1;
        external_start_pin = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic pdPulse();
        @(posedge core_clk);
        #1;
        powerDown = 1'b1;
        @(posedge core_clk);
        #1;
        check({9'h000, anaEnable}, 10'h000);
        powerDown = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic waitIrq();
        int k = 0;
        while (adcIrq !== 1'b1 && k < LEN + 10) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask
    task automatic tallyAndFinish();
        $display("comparisons %0d, mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A hang costs a mismatch and ends the run through the normal close.
    initial begin
        repeat (20000) @(posedge core_clk);
        numErrors++;
        $display("wrong value at %0t: watchdog expired", $time);
        tallyAndFinish();
    end
    initial begin
        {rstn, sfrAddr, sfrWrEn, sfrRdEn, sfrWrData, external_start_pin, powerDown} = '0;
        {level, numErrors, samplesChecked} = '0;
        void'($urandom(84957));
        repeat (3) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        rdChk(CONV_CONTROL_ADDR, CONTROL_RESET);
        rdChk(RESULT_LOW_ADDR, {CLKSEL_RESET, 6'h00});
        rdChk(PIN_SWITCH_ADDR, PIN_SWITCH_RESET);
        v = 8'($urandom);
        wr(PIN_SWITCH_ADDR, v);
        rdChk(PIN_SWITCH_ADDR, v);
        check({2'b00, anaPinMode}, {2'b00, v});
        wr(8'h00_C3, 8'h00_FF);
        rdChk(8'h00_C3, 8'h00_00);
        // Every channel and clock code, with a refused restart in mid-run.
        for (int i = 0; i < 8; i++) begin
            ch = 3'(i);
            cs = 2'(i);
            level = 10'($urandom);
            wr(RESULT_LOW_ADDR, {cs, 6'h00});
            wr(CONV_CONTROL_ADDR, {5'b10001, ch});
            rdChk(CONV_CONTROL_ADDR, {5'b10001, ch});
            check({7'h00, anaChannel}, {7'h00, ch});
            wr(CONV_CONTROL_ADDR, {5'b10001, ch});
            check({9'h000, anaConvert}, 10'h001);
            n = 0;
            last = adcClk;
            repeat (32) begin
                @(posedge core_clk);
                #1;
                n += int'(adcClk !== last);
                last = adcClk;
            end
            check(10'(n), 10'(32 / halfOf(cs)));
            waitIrq();
            check({9'h000, adcIrq}, 10'h001);
            rdChk(CONV_CONTROL_ADDR, {5'b10010, ch});
            r = expResult(level, ch);
            rdChk(RESULT_HIGH_ADDR, r[9:2]);
            rdChk(RESULT_LOW_ADDR, {cs, 4'h0, r[1:0]});
            wr(RESULT_HIGH_ADDR, ~r[9:2]);
            wr(RESULT_LOW_ADDR, {cs, 6'h3F});
            rdChk(RESULT_HIGH_ADDR, r[9:2]);
            rdChk(RESULT_LOW_ADDR, {cs, 4'h0, r[1:0]});
            wr(CONV_CONTROL_ADDR, {5'b10011, ch});
            check({9'h000, anaConvert}, 10'h000);
            wr(CONV_CONTROL_ADDR, {5'b10000, ch});
            check({9'h000, adcIrq}, 10'h000);
        end
        // External start off, then on, then aborted by power-down.
        wr(CONV_CONTROL_ADDR, 8'h00_80);
        pulse();
        check({9'h000, anaConvert}, 10'h000);
        wr(CONV_CONTROL_ADDR, 8'h00_A0);
        pulse();
        check({9'h000, anaConvert}, 10'h001);
        pdPulse();
        check({8'h00, anaConvert, adcIrq}, 10'h000);
        rdChk(RESULT_HIGH_ADDR, r[9:2]);
        level = 10'($urandom);
        pulse();
        waitIrq();
        r = expResult(level, 3'h0);
        rdChk(RESULT_HIGH_ADDR, r[9:2]);
        pdPulse();
        check({9'h000, adcIrq}, 10'h001);
        // Clearing the flag in the same write as a start refuses the start.
        wr(CONV_CONTROL_ADDR, 8'h00_88);
        check({8'h00, anaConvert, adcIrq}, 10'h000);
        wr(CONV_CONTROL_ADDR, 8'h00_88);
        wr(CONV_CONTROL_ADDR, 8'h00_08);
        check({8'h00, anaConvert, adcIrq}, 10'h000);
        wr(CONV_CONTROL_ADDR, 8'h00_08);
        check({9'h000, anaConvert}, 10'h000);
        tallyAndFinish();
    end
endmodule
